/* mu_consts.vh */
`ifndef MU_CONSTS_VH
`define MU_CONSTS_VH
// Register select values
`define MU_SEL_CMD_STAT   1'b0
`define MU_SEL_DATA       1'b1
// Command register fields
`define MU_CMD_RATE_HI    1
`define MU_CMD_RATE_LO    0
`define MU_CMD_TXC_HI     6
`define MU_CMD_TXC_LO     5
`define MU_CMD_RIE        7
// Status register bit positions
`define MU_ST_RXFULL      0
`define MU_ST_TXEMPTY     1
`define MU_ST_CTS         3
`define MU_ST_FE          4
`define MU_ST_OV          5
`define MU_ST_IRQ         7
// Bit rate codes
`define MU_RATE_9K6       2'h0
`define MU_RATE_31K25     2'h1
`define MU_RATE_38K4      2'h2
`define MU_RATE_RESET     2'h3
`define MU_RATE_RST_VAL   2'h3
// Transmit control codes
`define MU_TXC_RTS_NOIRQ  2'h0
`define MU_TXC_RTS_IRQ    2'h1
`define MU_TXC_NORTS      2'h2
`define MU_TXC_BREAK      2'h3
// Timing
`define MU_CLK_HZ         250000000
`define MU_RATE0_HZ       9600
`define MU_RATE1_HZ       31250
`define MU_RATE2_HZ       38400
`define MU_DATA_BITS      8
// Clock cycles per bit at 250 MHz, rounded down
`define MU_BIT_CYC0       16'h65b9
`define MU_BIT_CYC1       16'h1f40
`define MU_BIT_CYC2       16'h196e
`endif

/* mu_uart.v */
`timescale 1ns/100ps
`include "mu_consts.vh"

module mu_uart #(
    parameter [15:0] BIT_CYC0 = `MU_BIT_CYC0,
    parameter [15:0] BIT_CYC1 = `MU_BIT_CYC1,
    parameter [15:0] BIT_CYC2 = `MU_BIT_CYC2
) (
    // Clock and reset
    input  wire       ref_clk,
    input  wire       rst,
    // Host bus pins
    input  wire       serial_port_select_n,
    input  wire       register_select_bit,
    input  wire       rd_n,
    input  wire       wr_n,
    input  wire [7:0] host_data_in,
    output reg  [7:0] host_data_out,
    output wire       host_data_oe,
    output wire       irq,
    // Serial pins
    input  wire       serial_rx,
    input  wire       cts_n,
    output reg        serial_tx,
    output reg        rts_n
);
    localparam TX_IDLE  = 2'h0;
    localparam TX_START = 2'h1;
    localparam TX_DATA  = 2'h2;
    localparam TX_STOP  = 2'h3;
    localparam RX_IDLE  = 2'h0;
    localparam RX_START = 2'h1;
    localparam RX_DATA  = 2'h2;
    localparam RX_STOP  = 2'h3;

    // Two-stage synchronisers for all input pins except clock and reset
    reg  [12:0] sync1_reg;
    reg  [12:0] sync2_reg;
    wire [12:0] pins = {serial_port_select_n, register_select_bit, rd_n, wr_n,
                        host_data_in, serial_rx};
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sync1_reg <= 13'h1eff;
            sync2_reg <= 13'h1eff;
        end else begin
            sync1_reg <= pins;
            sync2_reg <= sync1_reg;
        end
    end
    reg cts1_reg;
    reg cts2_reg;
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cts1_reg <= 1'b1;
            cts2_reg <= 1'b1;
        end else begin
            cts1_reg <= cts_n;
            cts2_reg <= cts1_reg;
        end
    end
    wire       sel_n_s = sync2_reg[12];
    wire       rsel_s  = sync2_reg[11];
    wire       rd_n_s  = sync2_reg[10];
    wire       wr_n_s  = sync2_reg[9];
    wire [7:0] din_s   = sync2_reg[8:1];
    wire       rx_s    = sync2_reg[0];
    // Strobe edge detection on synchronised copies
    reg        rd_n_d_reg;
    reg        wr_n_d_reg;
    reg        wsel_reg;
    reg        wreg_reg;
    reg  [7:0] wdata_reg;
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rd_n_d_reg <= 1'b1;
            wr_n_d_reg <= 1'b1;
            wsel_reg   <= 1'b0;
            wreg_reg   <= 1'b0;
            wdata_reg  <= 8'h00;
        end else begin
            rd_n_d_reg <= rd_n_s;
            wr_n_d_reg <= wr_n_s;
            if (!wr_n_s) begin
                wsel_reg  <= !sel_n_s;
                wreg_reg  <= rsel_s;
                wdata_reg <= din_s;
            end
        end
    end
    wire rd_start = !rd_n_s && rd_n_d_reg && !sel_n_s;
    wire wr_done  = wr_n_s && !wr_n_d_reg && wsel_reg;
    wire wr_cmd   = wr_done && (wreg_reg == `MU_SEL_CMD_STAT);
    wire wr_data  = wr_done && (wreg_reg == `MU_SEL_DATA);
    wire rd_data  = rd_start && (rsel_s == `MU_SEL_DATA);
    assign host_data_oe = !sel_n_s && !rd_n_s;
    reg [1:0] rate_reg;
    reg [1:0] txc_reg;
    reg       rie_reg;
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rate_reg <= `MU_RATE_RST_VAL;
            txc_reg  <= `MU_TXC_RTS_NOIRQ;
            rie_reg  <= 1'b0;
        end else if (wr_cmd) begin
            rate_reg <= wdata_reg[`MU_CMD_RATE_HI:`MU_CMD_RATE_LO];
            txc_reg  <= wdata_reg[`MU_CMD_TXC_HI:`MU_CMD_TXC_LO];
            rie_reg  <= wdata_reg[`MU_CMD_RIE];
        end
    end
    // rate code 11 holds UART in reset
    wire soft_rst = (rate_reg == `MU_RATE_RESET);
    reg [15:0] bit_cyc;
    always @* begin
        case (rate_reg)
            `MU_RATE_9K6:   bit_cyc = BIT_CYC0;
            `MU_RATE_31K25: bit_cyc = BIT_CYC1;
            `MU_RATE_38K4:  bit_cyc = BIT_CYC2;
            default:        bit_cyc = BIT_CYC0;
        endcase
    end
    wire [15:0] half_cyc = {1'b0, bit_cyc[15:1]};
    reg  [7:0] txbuf_reg;
    reg        txfull_reg;
    reg  [1:0] txst_reg;
    reg  [7:0] txsh_reg;
    reg  [2:0] txbit_reg;
    reg [15:0] txcnt_reg;
    wire       cts_ok  = !cts2_reg;
    wire       tx_load = txfull_reg && (txst_reg == TX_IDLE) && cts_ok;
    wire       tx_tick = (txcnt_reg == 16'h0000);
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            txbuf_reg  <= 8'h00;
            txfull_reg <= 1'b0;
            txst_reg   <= TX_IDLE;
            txsh_reg   <= 8'h00;
            txbit_reg  <= 3'h0;
            txcnt_reg  <= 16'h0000;
        end else if (soft_rst) begin
            txfull_reg <= 1'b0;
            txst_reg   <= TX_IDLE;
            txcnt_reg  <= 16'h0000;
        end else begin
            // host writes fill the transmit buffer
            if (wr_data)
                txbuf_reg <= wdata_reg;
            // write clears empty, load sets it; write wins
            if (wr_data)
                txfull_reg <= 1'b1;
            else if (tx_load)
                txfull_reg <= 1'b0;
            if (!tx_tick)
                txcnt_reg <= txcnt_reg - 16'h0001;
            case (txst_reg)
                TX_IDLE: begin
                    if (tx_load) begin
                        txsh_reg  <= txbuf_reg;
                        txcnt_reg <= bit_cyc - 16'h0001;
                        txst_reg  <= TX_START;
                    end
                end
                TX_START: begin
                    if (tx_tick) begin
                        txcnt_reg <= bit_cyc - 16'h0001;
                        txbit_reg <= 3'h0;
                        txst_reg  <= TX_DATA;
                    end
                end
                TX_DATA: begin
                    if (tx_tick) begin
                        txcnt_reg <= bit_cyc - 16'h0001;
                        txsh_reg  <= {1'b0, txsh_reg[7:1]};
                        txbit_reg <= txbit_reg + 3'h1;
                        if (txbit_reg == 3'h7)
                            txst_reg <= TX_STOP;
                    end
                end
                TX_STOP: begin
                    if (tx_tick)
                        txst_reg <= TX_IDLE;
                end
                default: txst_reg <= TX_IDLE;
            endcase
        end
    end
    reg tx_line;
    always @* begin
        case (txst_reg)
            TX_START: tx_line = 1'b0;
            TX_DATA:  tx_line = txsh_reg[0];
            default:  tx_line = 1'b1;
        endcase
    end
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            serial_tx <= 1'b1;
            rts_n     <= 1'b1;
        end else begin
            serial_tx <= (txc_reg == `MU_TXC_BREAK && !soft_rst) ? 1'b0 : tx_line;
            rts_n     <= soft_rst || (txc_reg == `MU_TXC_NORTS);
        end
    end
    reg  [1:0] rxst_reg;
    reg  [7:0] rxsh_reg;
    reg  [2:0] rxbit_reg;
    reg [15:0] rxcnt_reg;
    reg  [7:0] rxbuf_reg;
    reg        rxfull_reg;
    reg        fe_reg;
    reg        ov_reg;
    reg        rx_d_reg;
    wire       rx_tick = (rxcnt_reg == 16'h0000);
    wire       rx_done = (rxst_reg == RX_STOP) && rx_tick;
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rxst_reg   <= RX_IDLE;
            rxsh_reg   <= 8'h00;
            rxbit_reg  <= 3'h0;
            rxcnt_reg  <= 16'h0000;
            rxbuf_reg  <= 8'h00;
            rxfull_reg <= 1'b0;
            fe_reg     <= 1'b0;
            ov_reg     <= 1'b0;
            rx_d_reg   <= 1'b1;
        end else if (soft_rst) begin
            rxst_reg   <= RX_IDLE;
            rxcnt_reg  <= 16'h0000;
            rxfull_reg <= 1'b0;
            fe_reg     <= 1'b0;
            ov_reg     <= 1'b0;
            rx_d_reg   <= 1'b1;
        end else begin
            rx_d_reg <= rx_s;
            if (!rx_tick)
                rxcnt_reg <= rxcnt_reg - 16'h0001;
            case (rxst_reg)
                RX_IDLE: begin
                    if (rx_d_reg && !rx_s) begin
                        rxcnt_reg <= half_cyc;
                        rxst_reg  <= RX_START;
                    end
                end
                RX_START: begin
                    if (rx_tick) begin
                        // False start bits are dropped
                        if (rx_s)
                            rxst_reg <= RX_IDLE;
                        else begin
                            rxcnt_reg <= bit_cyc - 16'h0001;
                            rxbit_reg <= 3'h0;
                            rxst_reg  <= RX_DATA;
                        end
                    end
                end
                RX_DATA: begin
                    if (rx_tick) begin
                        rxcnt_reg <= bit_cyc - 16'h0001;
                        rxsh_reg  <= {rx_s, rxsh_reg[7:1]};
                        rxbit_reg <= rxbit_reg + 3'h1;
                        if (rxbit_reg == 3'h7)
                            rxst_reg <= RX_STOP;
                    end
                end
                RX_STOP: begin
                    if (rx_tick)
                        rxst_reg <= RX_IDLE;
                end
                default: rxst_reg <= RX_IDLE;
            endcase
            if (rx_done) begin
                rxbuf_reg <= rxsh_reg;
                // framing error kept with its character
                fe_reg    <= !rx_s;
            end
            // new character wins over a clearing read
            if (rx_done)
                rxfull_reg <= 1'b1;
            else if (rd_data)
                rxfull_reg <= 1'b0;
            // overrun on overwrite, cleared by data read
            if (rx_done && rxfull_reg)
                ov_reg <= 1'b1;
            else if (rd_data)
                ov_reg <= 1'b0;
        end
    end

    // empty flag forced low while not clear to send
    wire tx_empty = !txfull_reg && cts_ok && !soft_rst;
    wire rx_irq = rie_reg && (rxfull_reg || ov_reg);
    wire tx_irq = (txc_reg == `MU_TXC_RTS_IRQ) && tx_empty;
    assign irq = rx_irq || tx_irq;
    reg [7:0] status;
    always @* begin
        status = 8'h00;
        status[`MU_ST_RXFULL]  = rxfull_reg;
        status[`MU_ST_TXEMPTY] = tx_empty;
        status[`MU_ST_CTS]     = cts2_reg;
        status[`MU_ST_FE]      = fe_reg;
        status[`MU_ST_OV]      = ov_reg;
        status[`MU_ST_IRQ]     = irq;
    end
    always @(posedge ref_clk or posedge rst) begin
        if (rst)
            host_data_out <= 8'h00;
        else if (rd_start)
            host_data_out <= (rsel_s == `MU_SEL_DATA) ? rxbuf_reg : status;
    end
endmodule

/* mu_uart_assertions.sv */
`timescale 1ns/100ps
module mu_uart_chk (
    // Clock and reset
    input wire       ref_clk,
    input wire       rst,
    // Host bus
    input wire       serial_port_select_n,
    input wire       register_select_bit,
    input wire       rd_n,
    input wire       wr_n,
    input wire [7:0] host_data_in,
    input wire [7:0] host_data_out,
    input wire       host_data_oe,
    input wire       irq,
    // Serial side
    input wire       serial_rx,
    input wire       cts_n,
    input wire       serial_tx,
    input wire       rts_n
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence s_stat_rd;
        $rose(host_data_oe) && !$past(register_select_bit, 2);
    endsequence
    sequence s_cmd_rate_rst;
        $rose(wr_n) && !serial_port_select_n && !register_select_bit && host_data_in[1:0] == 2'h3;
    endsequence
    property p_oe_src; host_data_oe |-> !$past(rd_n, 2) && !$past(serial_port_select_n, 2); endproperty
    property p_oe_on; (!rd_n && !serial_port_select_n)[*3] |-> host_data_oe; endproperty
    property p_oe_off; rd_n[*3] |-> !host_data_oe; endproperty
    property p_sel_off; serial_port_select_n[*3] |-> !host_data_oe; endproperty
    property p_stat; s_stat_rd |=> host_data_out[7] == $past(irq) && host_data_out[3] == $past(cts_n, 3)
        && !(host_data_out[3] && host_data_out[1]) && host_data_out[6] == 1'b0 && host_data_out[2] == 1'b0;
    endproperty
    property p_rate_rst; s_cmd_rate_rst |-> ##[1:6] rts_n; endproperty
    property p_rst_idle; $fell(rst) |-> serial_tx && rts_n && !irq && !host_data_oe; endproperty
    property p_tx_hold; $changed(serial_tx) |=> $stable(serial_tx)[*8]; endproperty
    a_oe_src: assert property (p_oe_src) else $error("read enable without select and strobe");
    a_oe_on: assert property (p_oe_on) else $error("read enable missing");
    a_oe_off: assert property (p_oe_off) else $error("read enable after strobe");
    a_sel_off: assert property (p_sel_off) else $error("read enable while unselected");
    a_stat: assert property (p_stat) else $error("status bits wrong");
    a_rate_rst: assert property (p_rate_rst) else $error("rate reset code ignored");
    a_rst_idle: assert property (p_rst_idle) else $error("not idle after reset");
    a_tx_hold: assert property (p_tx_hold) else $error("serial bit too short");
endmodule
bind mu_uart mu_uart_chk u_chk (.ref_clk(ref_clk), .rst(rst), .serial_port_select_n(serial_port_select_n),
    .register_select_bit(register_select_bit), .rd_n(rd_n), .wr_n(wr_n), .host_data_in(host_data_in),
    .host_data_out(host_data_out), .host_data_oe(host_data_oe), .irq(irq), .serial_rx(serial_rx),
    .cts_n(cts_n), .serial_tx(serial_tx), .rts_n(rts_n));

/* mu_midi_dev.sv */
`timescale 1ns/100ps
module mu_midi_dev (
    input  wire       ref_clk,
    input  wire       serial_tx,
    output logic      serial_rx,
    output logic      cts_n
);
    int         bit_cyc = 20;
    int         rx_cnt = 0;
    logic [7:0] got;
    initial begin
        serial_rx = 1'b1;
        cts_n = 1'b1;
    end
    task automatic send(input logic [7:0] b, input logic stop);
        logic [9:0] fr;
        fr = {stop, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            serial_rx <= fr[i];
            repeat (bit_cyc) @(negedge ref_clk);
        end
        serial_rx <= 1'b1;
        repeat (bit_cyc) @(negedge ref_clk);
    endtask
    always @(negedge serial_tx) begin
        repeat (bit_cyc / 2) @(posedge ref_clk);
        for (int i = 0; i < 8; i++) begin
            repeat (bit_cyc) @(posedge ref_clk);
            got[i] = serial_tx;
        end
        repeat (bit_cyc) @(posedge ref_clk);
        rx_cnt++;
    end
endmodule

/* midi_uart_host_port_tb_top.sv */
`timescale 1ns/100ps
module midi_uart_host_port_tb_top;
    logic       ref_clk;
    logic       rst;
    logic       serial_port_select_n;
    logic       register_select_bit;
    logic       rd_n;
    logic       wr_n;
    logic [7:0] host_data_in;
    wire  [7:0] host_data_out;
    wire        host_data_oe;
    wire        irq;
    wire        serial_rx;
    wire        cts_n;
    wire        serial_tx;
    wire        rts_n;
    logic [7:0] rd_val;
    int         errors = 0;
    int         samples_checked = 0;
    int         cyc[3] = '{16, 20, 24};

    mu_uart #(.BIT_CYC0(16'd16), .BIT_CYC1(16'd20), .BIT_CYC2(16'd24)) dut (.ref_clk(ref_clk), .rst(rst),
        .serial_port_select_n(serial_port_select_n), .register_select_bit(register_select_bit), .rd_n(rd_n),
        .wr_n(wr_n), .host_data_in(host_data_in), .host_data_out(host_data_out), .host_data_oe(host_data_oe),
        .irq(irq), .serial_rx(serial_rx), .cts_n(cts_n), .serial_tx(serial_tx), .rts_n(rts_n));
    mu_midi_dev pm (.ref_clk(ref_clk), .serial_tx(serial_tx), .serial_rx(serial_rx), .cts_n(cts_n));

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // Strobe held 152 ns, select and data held past the strobe release
    task automatic bus(input logic rs, input logic wr, input logic [7:0] d);
        @(negedge ref_clk);
        serial_port_select_n = 1'b0;
        register_select_bit = rs;
        host_data_in = d;
        if (wr) wr_n = 1'b0; else rd_n = 1'b0;
        repeat (38) @(negedge ref_clk);
        rd_val = host_data_out;
        wr_n = 1'b1;
        rd_n = 1'b1;
        repeat (3) @(negedge ref_clk);
        serial_port_select_n = 1'b1;
        repeat (20) @(negedge ref_clk);
    endtask
    task automatic st(input logic [7:0] exp);
        bus(1'b0, 1'b0, 8'h00);
        chk(rd_val, exp, "status");
    endtask
    task automatic wait_tx(input int n);
        for (int i = 0; i < 5000 && pm.rx_cnt < n; i++) @(negedge ref_clk);
    endtask

    task automatic t_reset;
        st(8'h08);
        chk({7'h0, rts_n}, 8'h01, "rts idle");
        $display("test reset done");
    endtask
    task automatic t_rates;
        int n;
        for (int r = 0; r < 3; r++) begin
            pm.bit_cyc = cyc[r];
            pm.cts_n = 1'b1;
            n = pm.rx_cnt;
            bus(1'b0, 1'b1, {6'h0, r[1:0]});
            bus(1'b1, 1'b1, 8'h5a ^ r[7:0]);
            st(8'h08);
            chk(pm.rx_cnt[7:0], n[7:0], "held by cts");
            pm.cts_n = 1'b0;
            wait_tx(n + 1);
            chk(pm.rx_cnt[7:0], n[7:0] + 8'h01, "tx count");
            chk(pm.got, 8'h5a ^ r[7:0], "tx byte");
            st(8'h02);
        end
        $display("test rates done");
    endtask
    task automatic t_irq;
        bus(1'b0, 1'b1, 8'h22);
        st(8'h82);
        chk({7'h0, irq}, 8'h01, "tx irq");
        bus(1'b0, 1'b1, 8'h42);
        chk({6'h0, irq, rts_n}, 8'h01, "rts off");
        $display("test irq done");
    endtask
    task automatic t_rx;
        int n;
        bus(1'b0, 1'b1, 8'h82);
        pm.send(8'h3c, 1'b1);
        n = pm.rx_cnt;
        bus(1'b1, 1'b1, 8'h77);
        st(8'h83);
        bus(1'b1, 1'b0, 8'h00);
        chk(rd_val, 8'h3c, "rx byte");
        wait_tx(n + 1);
        chk(pm.rx_cnt[7:0], n[7:0] + 8'h01, "tx count");
        chk(pm.got, 8'h77, "tx while rx");
        st(8'h02);
        pm.send(8'h11, 1'b1);
        pm.send(8'hc3, 1'b0);
        st(8'hb3);
        bus(1'b1, 1'b0, 8'h00);
        chk(rd_val, 8'hc3, "overwrite");
        bus(1'b0, 1'b0, 8'h00);
        chk(rd_val & 8'hef, 8'h02, "after read");
        $display("test rx done");
    endtask
    task automatic t_break;
        bus(1'b0, 1'b1, 8'h62);
        repeat (40) @(negedge ref_clk);
        chk({6'h0, rts_n, serial_tx}, 8'h00, "break");
        bus(1'b0, 1'b1, 8'h03);
        chk({6'h0, rts_n, serial_tx}, 8'h03, "rate reset");
        st(8'h00);
        $display("test break done");
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        #200000;
        errors++;
        $display("CHECK FAILED %0t watchdog", $time);
        results;
    end
    initial begin
        rst = 1'b1;
        serial_port_select_n = 1'b1;
        register_select_bit = 1'b0;
        rd_n = 1'b1;
        wr_n = 1'b1;
        host_data_in = 8'h00;
        repeat (20) @(negedge ref_clk);
        rst = 1'b0;
        t_reset;
        t_rates;
        t_irq;
        t_rx;
        t_break;
        results;
    end
endmodule
